// ### hdl/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of unrelated levels
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // ----------------------------------------
    // Stage one feeds stage two only
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// ### hdl/spi_port_pkg.sv
package spi_port_pkg;

    // ----------------------------------------
    // Widths and counts
    // ----------------------------------------
    localparam int BYTE_W = 8;
    localparam int BIT_CNT_W = 3;
    localparam int SYNC_W = 7;
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [BYTE_W-1:0] TX_IDLE = 8'h00;
    localparam logic [BYTE_W-1:0] RX_RESET = 8'h00;

    // Cycles after reset release before the strap is caught
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // Host serial clock ceiling, for reference by the bench
    localparam int SCK_MAX_MHZ = 48;
    localparam int SYS_CLK_MHZ = 200;

    // ----------------------------------------
    // Bit positions in the synchroniser bus
    // ----------------------------------------
    localparam int SY_SCK = 0;
    localparam int SY_SEL = 1;
    localparam int SY_MOSI = 2;
    localparam int SY_RST = 3;
    localparam int SY_CFG = 4;
    localparam int SY_CEN = 5;
    localparam int SY_CPOL = 6;

    // ----------------------------------------
    // Frame states, Gray along idle-start-busy
    // ----------------------------------------
    typedef enum logic [1:0] {
        FRAME_IDLE = 2'b00,
        FRAME_START = 2'b01,
        FRAME_BUSY = 2'b11
    } frame_state_t;

endpackage

// ### hdl/spi_slave_host_port.sv
`timescale 1ns/1ps
module spi_slave_host_port (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Host pins
    input wire logic sck_i,
    input wire logic slave_select_low_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic host_reset_low_i,
    input wire logic chip_en_i,
    input wire logic port_cfg_strap_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    output logic host_attention_low_o,
    // Core side
    output logic core_power_on_o,
    output logic port_ready_o,
    output logic frame_start_o,
    output logic frame_end_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic [7:0] byte_count_o,
    input wire logic [7:0] tx_byte_i,
    output logic tx_take_o,
    input wire logic attention_event_i,
    input wire logic attention_service_i
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [spi_port_pkg::SYNC_W-1:0] pins_raw;
    logic [spi_port_pkg::SYNC_W-1:0] pins_s;
    logic cpha_s;

    assign pins_raw = {cpol_i, chip_en_i, port_cfg_strap_i,
                       host_reset_low_i, mosi_i, slave_select_low_i, sck_i};

    pin_sync #(
        .W(spi_port_pkg::SYNC_W)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );

    // Phase pin on its own pair so the bus stays one clean bundle
    pin_sync #(.W(1)) u_sync_cpha (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .async_i(cpha_i),
        .sync_o(cpha_s)
    );

    // ----------------------------------------
    // Edge selection
    // ----------------------------------------
    // Pick leading or trailing edge by phase
    function automatic logic pick_edge(input logic sel, input logic lead,
                                       input logic trail);
        pick_edge = sel ? trail : lead;
    endfunction

    logic sck_prev_q, cpol_q, cpha_q, port_en_q;
    logic sck_rise, sck_fall, lead_edge, trail_edge;
    logic sample_edge, shift_edge, selected;
    logic [1:0] strap_cnt_q;
    spi_port_pkg::frame_state_t state_q;
    assign sck_rise = pins_s[spi_port_pkg::SY_SCK] & ~sck_prev_q;
    assign sck_fall = ~pins_s[spi_port_pkg::SY_SCK] & sck_prev_q;
    assign lead_edge = cpol_q ? sck_fall : sck_rise;
    assign trail_edge = cpol_q ? sck_rise : sck_fall;
    assign sample_edge = pick_edge(cpha_q, lead_edge, trail_edge);
    assign shift_edge = pick_edge(cpha_q, trail_edge, lead_edge);
    // Bus traffic counts only while selected and out of host reset
    assign selected = ~pins_s[spi_port_pkg::SY_SEL]
                    & pins_s[spi_port_pkg::SY_RST] & port_en_q;

    // Previous clock sample for edge finding
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            sck_prev_q <= 1'b0;
        else
            sck_prev_q <= pins_s[spi_port_pkg::SY_SCK];
    end

    // ----------------------------------------
    // Strap capture after reset release
    // ----------------------------------------
    // Waits for the synchroniser to settle; strap never read during reset
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_cnt_q <= 2'h0;
            port_en_q <= 1'b0;
        end
        else if (strap_cnt_q != spi_port_pkg::STRAP_WAIT)
        begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q + 2'h1 == spi_port_pkg::STRAP_WAIT)
                port_en_q <= pins_s[spi_port_pkg::SY_CFG];
        end
    end

    // ----------------------------------------
    // Frame state and mode latch
    // ----------------------------------------
    // Mode is frozen per frame so a cpol or cpha pin change cannot split a byte
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= spi_port_pkg::FRAME_IDLE;
            cpol_q <= 1'b0;
            cpha_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                spi_port_pkg::FRAME_IDLE:
                begin
                    cpol_q <= pins_s[spi_port_pkg::SY_CPOL];
                    cpha_q <= cpha_s;
                    if (selected)
                        state_q <= spi_port_pkg::FRAME_START;
                end
                spi_port_pkg::FRAME_START:
                    state_q <= selected ? spi_port_pkg::FRAME_BUSY
                                        : spi_port_pkg::FRAME_IDLE;
                spi_port_pkg::FRAME_BUSY:
                    if (!selected)
                        state_q <= spi_port_pkg::FRAME_IDLE;
                default:
                    state_q <= spi_port_pkg::FRAME_IDLE;
            endcase
        end
    end

    logic in_frame;
    assign in_frame = (state_q == spi_port_pkg::FRAME_BUSY) & selected;

    // ----------------------------------------
    // Receive shifter and counters
    // ----------------------------------------
    logic [2:0] bit_cnt_q;
    logic [6:0] rx_sr_q;

    // One byte every eight sample edges, upward to the core
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            bit_cnt_q <= spi_port_pkg::BIT_FIRST;
            rx_sr_q <= 7'h00;
            rx_byte_o <= spi_port_pkg::RX_RESET;
            rx_valid_o <= 1'b0;
            byte_count_o <= 8'h00;
        end
        else
        begin
            rx_valid_o <= 1'b0;
            if (!selected)
            begin
                bit_cnt_q <= spi_port_pkg::BIT_FIRST;
                byte_count_o <= 8'h00;
            end
            else if (in_frame && sample_edge)
            begin
                rx_sr_q <= {rx_sr_q[5:0], pins_s[spi_port_pkg::SY_MOSI]};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == spi_port_pkg::BIT_LAST)
                begin
                    rx_byte_o <= {rx_sr_q, pins_s[spi_port_pkg::SY_MOSI]};
                    rx_valid_o <= 1'b1;
                    byte_count_o <= byte_count_o + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // Transmit shifter
    // ----------------------------------------
    logic [7:0] tx_sr_q;
    logic first_q;

    // Phase 0 presents bit 7 at select; phase 1 waits for the lead edge
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_sr_q <= spi_port_pkg::TX_IDLE;
            first_q <= 1'b0;
            miso_o <= 1'b0;
            tx_take_o <= 1'b0;
        end
        else
        begin
            tx_take_o <= 1'b0;
            if (state_q == spi_port_pkg::FRAME_START)
            begin
                tx_sr_q <= tx_byte_i;
                tx_take_o <= 1'b1;
                first_q <= cpha_q;
                if (!cpha_q)
                    miso_o <= tx_byte_i[7];
            end
            else if (in_frame && shift_edge)
            begin
                if (first_q)
                begin
                    first_q <= 1'b0;
                    miso_o <= tx_sr_q[7];
                end
                else if (bit_cnt_q == spi_port_pkg::BIT_FIRST)
                begin
                    // Byte boundary: next reply byte from the core
                    tx_sr_q <= tx_byte_i;
                    tx_take_o <= 1'b1;
                    miso_o <= tx_byte_i[7];
                end
                else
                begin
                    tx_sr_q <= {tx_sr_q[6:0], 1'b0};
                    miso_o <= tx_sr_q[6];
                end
            end
        end
    end

    // ----------------------------------------
    // Output enable and frame strobes
    // ----------------------------------------
    // Released the cycle after selected drops, shared bus stays clean
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            miso_oe_n_o <= 1'b1;
            frame_start_o <= 1'b0;
            frame_end_o <= 1'b0;
        end
        else
        begin
            miso_oe_n_o <= ~(selected
                             && state_q != spi_port_pkg::FRAME_IDLE);
            frame_start_o <= (state_q == spi_port_pkg::FRAME_START);
            frame_end_o <= (state_q == spi_port_pkg::FRAME_BUSY) & ~selected;
        end
    end

    // ----------------------------------------
    // Sideband: power, ready, attention
    // ----------------------------------------
    logic pending_q;

    // New event wins over a service in the same cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pending_q <= 1'b0;
            host_attention_low_o <= 1'b1;
            core_power_on_o <= 1'b0;
            port_ready_o <= 1'b0;
        end
        else
        begin
            if (attention_event_i)
                pending_q <= 1'b1;
            else if (attention_service_i)
                pending_q <= 1'b0;
            host_attention_low_o <= ~(attention_event_i | (pending_q
                & ~attention_service_i));
            core_power_on_o <= pins_s[spi_port_pkg::SY_CEN];
            port_ready_o <= port_en_q & pins_s[spi_port_pkg::SY_RST];
        end
    end

endmodule

// ### sim/spi_host_model.sv
`timescale 1ns/1ps
// --------
// Host master, 64 ns serial period
// --------
module spi_host_model (
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic miso_i,
    input wire logic miso_oe_n_i,
    output logic sck_o,
    output logic slave_select_low_o,
    output logic mosi_o
);
    // Idle: deselected, clock parked
    initial
    begin
        sck_o = 1'b0;
        slave_select_low_o = 1'b1;
        mosi_o = 1'b0;
    end

    // One frame, MSB first; a floated miso reads as unknown
    task automatic frame(input int nb, input logic [15:0] tx,
        output logic [15:0] rx);
        rx = 16'h0000;
        sck_o = cpol_i;
        slave_select_low_o = 1'b0;
        #64;
        for (int i = nb - 1; i >= 0; i--)
        begin
            if (!cpha_i) mosi_o = tx[i];
            #32 sck_o = !cpol_i;
            if (cpha_i) mosi_o = tx[i];
            else rx[i] = miso_oe_n_i ? 1'bx : miso_i;
            #32 sck_o = cpol_i;
            if (cpha_i) rx[i] = miso_oe_n_i ? 1'bx : miso_i;
        end
        #64 slave_select_low_o = 1'b1;
        mosi_o = !mosi_o; // Inverted line, never a stale value
        #64;
    endtask
endmodule

// ### sim/spi_port_chk.sv
`timescale 1ns/1ps
// --------
// Port checker
// --------
module spi_port_chk (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic sck_i,
    input wire logic slave_select_low_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic miso_o,
    input wire logic miso_oe_n_o,
    input wire logic chip_en_i,
    input wire logic core_power_on_o,
    input wire logic port_ready_o,
    input wire logic frame_start_o,
    input wire logic frame_end_o,
    input wire logic [7:0] byte_count_o,
    input wire logic attention_event_i,
    input wire logic attention_service_i,
    input wire logic host_attention_low_o
);
    // One domain, so one clock and reset for all
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    a_deselect_float: assert property (
        slave_select_low_i [*6] |-> miso_oe_n_o)
        else $error("miso driven while deselected");
    a_start_drive: assert property (
        frame_start_o |-> ##[0:2] !miso_oe_n_o)
        else $error("miso not driven at frame start");
    a_start_ready: assert property (
        frame_start_o |-> port_ready_o)
        else $error("frame started while port not ready");
    a_end_clear: assert property (
        frame_end_o |-> ##[0:3] (byte_count_o == 8'h00))
        else $error("byte count kept after deselect");
    // Sync delay is three cycles, six leaves margin
    a_power_on: assert property (
        chip_en_i [*6] |-> core_power_on_o)
        else $error("core power off with enable high");
    a_power_off: assert property (
        !chip_en_i [*6] |-> !core_power_on_o)
        else $error("core power on with enable low");
    a_attn_set: assert property (
        attention_event_i |=> !host_attention_low_o)
        else $error("attention not raised");
    a_attn_hold: assert property (
        !host_attention_low_o && !attention_service_i
        |=> !host_attention_low_o)
        else $error("attention dropped unserviced");
    a_attn_clear: assert property (
        attention_service_i && !attention_event_i
        |=> host_attention_low_o)
        else $error("attention not cleared");
    // A change while the clock is high means launch on the wrong edge
    a_mode0_launch: assert property (
        !cpol_i && !cpha_i && !miso_oe_n_o && $changed(miso_o)
        |-> !sck_i)
        else $error("mode 0 bit not launched after fall");
endmodule

bind spi_slave_host_port spi_port_chk chk_u (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sck_i(sck_i),
    .slave_select_low_i(slave_select_low_i), .cpol_i(cpol_i),
    .cpha_i(cpha_i), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
    .chip_en_i(chip_en_i), .core_power_on_o(core_power_on_o),
    .port_ready_o(port_ready_o), .frame_start_o(frame_start_o),
    .frame_end_o(frame_end_o), .byte_count_o(byte_count_o),
    .attention_event_i(attention_event_i),
    .attention_service_i(attention_service_i),
    .host_attention_low_o(host_attention_low_o));

// ### sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("Error t=%0t got %0h exp %0h", $time, g, e); \
        end \
    end

module tb_top;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sck, sel_n, mosi, miso, oe_n, attn_low, power_on, ready;
    logic f_start, f_end, rx_valid, tx_take, rv_q;
    logic host_rst_low = 1'b1;
    logic strap = 1'b1;
    logic chip_en = 1'b1;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic ev = 1'b0;
    logic svc = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rx_byte, byte_count;
    logic [7:0] rx_q[$];
    logic [7:0] take_q[$];
    int seed = 32'hD484;
    int miscompares = 0;
    int n_compared = 0;

    always #2.5 clk_sys_i = !clk_sys_i;

    spi_host_model host_u (.cpol_i(cpol), .cpha_i(cpha), .miso_i(miso),
        .miso_oe_n_i(oe_n), .sck_o(sck), .slave_select_low_o(sel_n),
        .mosi_o(mosi));
    // Strap held high except in the refused-port scenario
    spi_slave_host_port dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .sck_i(sck), .slave_select_low_i(sel_n), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_n_o(oe_n),
        .host_reset_low_i(host_rst_low), .chip_en_i(chip_en),
        .port_cfg_strap_i(strap), .cpol_i(cpol), .cpha_i(cpha),
        .host_attention_low_o(attn_low),
        .core_power_on_o(power_on), .port_ready_o(ready),
        .frame_start_o(f_start), .frame_end_o(f_end), .rx_byte_o(rx_byte),
        .rx_valid_o(rx_valid), .byte_count_o(byte_count),
        .tx_byte_i(tx_byte), .tx_take_o(tx_take),
        .attention_event_i(ev), .attention_service_i(svc));

    // Record taken and received bytes, refresh reply byte
    always @(posedge clk_sys_i)
    begin
        if (tx_take)
        begin
            take_q.push_back(tx_byte);
            tx_byte <= 8'($random(seed));
        end
        if (rx_valid)
            rx_q.push_back(rx_byte);
        rv_q <= rx_valid;
        if (rv_q)
            `CHK(byte_count, 8'(rx_q.size()))
    end

    function automatic logic [15:0] pack2(logic [7:0] a, logic [7:0] b);
        return {a, b};
    endfunction

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Bounded wait, the port needs the strap caught first
    task automatic wait_ready();
        int n = 0;
        while (ready !== 1'b1 && n < 50)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (ready !== 1'b1)
        begin
            miscompares++;
            finish_test();
        end
    endtask

    // Mode set while idle, then one frame of nb bits
    task automatic run_frame(input int nb, input logic [1:0] mode);
        logic [15:0] tx;
        logic [15:0] rx;
        @(posedge clk_sys_i);
        cpol <= mode[1];
        cpha <= mode[0];
        tx = 16'($random(seed));
        rx_q.delete();
        take_q.delete();
        repeat (8) @(posedge clk_sys_i);
        // Off the clock edge, so no pin moves as the synchroniser samples
        #1.25;
        host_u.frame(nb, tx, rx);
        `CHK(rx_q.size(), nb / 8)
        if (nb == 16)
        begin
            `CHK(pack2(rx_q[0], rx_q[1]), tx)
            `CHK(rx, pack2(take_q[0], take_q[1]))
        end
        `CHK(byte_count, 8'h00)
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        `CHK(oe_n, 1'b1)
        `CHK(attn_low, 1'b1)
        rstn_i <= 1'b1;
        wait_ready();
        `CHK(power_on, 1'b1)
        for (int m = 0; m < 4; m++)
            run_frame(16, 2'(m));
        run_frame(11, 2'h0);
        run_frame(3, 2'h0);
        repeat (6)
            run_frame(16, 2'($random(seed)));
        // Attention: raise, hold, set beats clear, then clear
        @(posedge clk_sys_i);
        ev <= 1'b1;
        @(posedge clk_sys_i);
        ev <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        `CHK(attn_low, 1'b0)
        ev <= 1'b1;
        svc <= 1'b1;
        @(posedge clk_sys_i);
        ev <= 1'b0;
        svc <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        `CHK(attn_low, 1'b0)
        svc <= 1'b1;
        @(posedge clk_sys_i);
        svc <= 1'b0;
        @(posedge clk_sys_i);
        `CHK(attn_low, 1'b1)
        // Power down and back up
        host_rst_low <= 1'b0;
        chip_en <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        `CHK(ready, 1'b0)
        `CHK(power_on, 1'b0)
        host_rst_low <= 1'b1;
        chip_en <= 1'b1;
        wait_ready();
        run_frame(16, 2'h0);
        // Reset again with the strap low: port must stay refused
        @(posedge clk_sys_i);
        strap <= 1'b0;
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        `CHK(oe_n, 1'b1)
        rstn_i <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        `CHK(ready, 1'b0)
        finish_test();
    end
endmodule
